//--- inc/exc_seq_pkg.sv
// Purpose: shared constants for the exception sequencer
// Assumes: byte addressing, 32-bit vector table entries
// Notes:   register offsets are byte addresses on the plain register port

package exc_seq_pkg;

	// ----------------------------------------------------------------
	// vector numbers
	// ----------------------------------------------------------------
	localparam logic [7:0] VEC_RST_PC   = 8'h00;
	localparam logic [7:0] VEC_RST_SP   = 8'h01;
	localparam logic [7:0] VEC_ILL_GEN  = 8'h04;
	localparam logic [7:0] VEC_ILL_SLOT = 8'h06;
	localparam logic [7:0] VEC_AERR_CPU = 8'h09;
	localparam logic [7:0] VEC_AERR_DMA = 8'h0A;
	localparam logic [7:0] VEC_NMI      = 8'h0B;
	localparam logic [7:0] VEC_UBRK     = 8'h0C;
	localparam logic [7:0] VEC_IRQ_BASE = 8'h40;
	localparam logic [7:0] VEC_PERI_LO  = 8'h48;

	// ----------------------------------------------------------------
	// reset values, levels and counts
	// ----------------------------------------------------------------
	localparam logic [31:0] VBR_RESET   = 32'h0000_0000;
	localparam logic [3:0]  MASK_RESET  = 4'hF;
	localparam logic [3:0]  MASK_NMI    = 4'hF;
	localparam logic [3:0]  LVL_UBRK    = 4'hF;
	localparam logic [31:0] STACK_WORD  = 32'h0000_0004;
	localparam int          SR_MASK_LSB = 4;
	localparam logic [4:0]  RST_MIN_CYC = 5'h14;

	// ----------------------------------------------------------------
	// access sizes
	// ----------------------------------------------------------------
	localparam logic [1:0] SIZE_BYTE = 2'h0;
	localparam logic [1:0] SIZE_WORD = 2'h1;
	localparam logic [1:0] SIZE_LONG = 2'h2;

	// ----------------------------------------------------------------
	// register offsets
	// ----------------------------------------------------------------
	localparam logic [7:0] REG_VBR  = 8'h00;
	localparam logic [7:0] REG_MASK = 8'h04;
	localparam logic [7:0] REG_MODE = 8'h08;
	localparam logic [7:0] REG_STAT = 8'h0C;

	// ----------------------------------------------------------------
	// sequencer states, gray along the reset and stacking paths
	// ----------------------------------------------------------------
	typedef enum logic [3:0] {
		ST_HOLD    = 4'h0,
		ST_RST_PC  = 4'h1,
		ST_RST_SP  = 4'h3,
		ST_RST_INI = 4'h2,
		ST_RUN     = 4'h6,
		ST_PUSH_SR = 4'h7,
		ST_PUSH_PC = 4'h5,
		ST_FETCH   = 4'h4,
		ST_JUMP    = 4'hC
	} seq_state_t;

endpackage

//--- verilog/exception_sequencer.sv
// Purpose: exception ranking, vector fetch, reset and stacking sequencer
// Assumes: single clock ref_clk_i at 20 MHz, memory port acked on same clock
// Notes:   the reset pin is synchronised here; peripherals follow periph_rst_o
//
// The implementer's own choices: the register offsets and strobed register access.
`timescale 1ns/1ps

module exception_sequencer #(
	parameter logic [31:0] PERI_BASE   = 32'hF000_0000,
	parameter logic [31:0] PERI_LIMIT  = 32'hF0FF_FFFF,
	parameter logic [31:0] PERI8_BASE  = 32'hF000_0000,
	parameter logic [31:0] PERI8_LIMIT = 32'hF00F_FFFF,
	parameter logic [31:0] EXT_BASE    = 32'h1000_0000,
	parameter logic [31:0] EXT_LIMIT   = 32'hEFFF_FFFF
) (
	input  wire logic        ref_clk_i,
	input  wire logic        arst_n_i,
	input  wire logic        external_reset_pin_n_i,
	input  wire logic [7:0]  reg_addr_i,
	input  wire logic [31:0] reg_wdata_i,
	input  wire logic        reg_wr_i,
	input  wire logic        reg_rd_i,
	output logic      [31:0] reg_rdata_o,
	input  wire logic        dec_valid_i,
	input  wire logic        dec_in_slot_i,
	input  wire logic        dec_undef_i,
	input  wire logic        dec_pc_write_i,
	input  wire logic        dec_int_block_i,
	input  wire logic [31:0] dec_pc_i,
	input  wire logic        instr_done_i,
	input  wire logic [31:0] next_pc_i,
	input  wire logic [31:0] slot_target_i,
	input  wire logic        trap_exec_i,
	input  wire logic [7:0]  trap_vec_i,
	input  wire logic        nmi_req_i,
	input  wire logic        ubrk_req_i,
	input  wire logic        int_req_i,
	input  wire logic        int_ext_i,
	input  wire logic [2:0]  int_line_i,
	input  wire logic [7:0]  int_vec_i,
	input  wire logic [3:0]  int_level_i,
	input  wire logic        bus_valid_i,
	input  wire logic        bus_dma_i,
	input  wire logic        bus_fetch_i,
	input  wire logic [1:0]  bus_size_i,
	input  wire logic [31:0] bus_addr_i,
	input  wire logic [31:0] status_word_i,
	input  wire logic [31:0] stack_pointer_gpr_i,
	output logic             mem_req_o,
	output logic             mem_we_o,
	output logic      [31:0] mem_addr_o,
	output logic      [31:0] mem_wdata_o,
	input  wire logic        mem_ack_i,
	input  wire logic [31:0] mem_rdata_i,
	output logic             pc_load_o,
	output logic      [31:0] pc_val_o,
	output logic             sp_load_o,
	output logic      [31:0] sp_val_o,
	output logic      [3:0]  imask_o,
	output logic             cpu_hold_o,
	output logic             periph_rst_o,
	output logic             aerr_o,
	output logic             int_ack_o,
	output logic      [7:0]  exc_vec_o
);
	import exc_seq_pkg::*;

	// ----------------------------------------------------------------
	// helpers
	// ----------------------------------------------------------------
	function automatic logic [31:0] vec_addr(input logic [31:0] base, input logic [7:0] vec,
		input logic use_base);
		vec_addr = (use_base ? base : 32'h0) + {22'h0, vec, 2'b00};
	endfunction

	function automatic logic in_range(input logic [31:0] a, input logic [31:0] lo,
		input logic [31:0] hi);
		in_range = (a >= lo) && (a <= hi);
	endfunction

	// ----------------------------------------------------------------
	// state
	// ----------------------------------------------------------------
	seq_state_t  state_q, state_d;
	logic        pin_s1_q, pin_s2_q, pin_s3_q, pin_level_q;
	logic [4:0]  low_cnt_q;
	logic [31:0] vbr_q;
	logic [3:0]  mask_q;
	logic        single_chip_q;
	logic        aerr_cpu_q, aerr_dma_q;
	logic        async_q, async_int_q;
	logic [7:0]  async_vec_q;
	logic [3:0]  async_lvl_q;
	logic [7:0]  exc_vec_q;
	logic        exc_int_q;
	logic [3:0]  exc_lvl_q;
	logic [31:0] save_pc_q, sp_base_q, pc_tmp_q;
	logic [31:0] vec_tgt_q, mem_sp_q;

	// ----------------------------------------------------------------
	// reset pin: three stages, level changes once stages two and three agree
	// ----------------------------------------------------------------
	wire pin_agree   = (pin_s2_q == pin_s3_q);
	wire pin_level_d = pin_agree ? pin_s3_q : pin_level_q;
	wire pin_release = ~pin_level_q & pin_level_d;
	wire rst_armed   = (low_cnt_q >= RST_MIN_CYC);
	wire in_reset    = ~pin_level_q;

	// ----------------------------------------------------------------
	// bus cycle checks
	// ----------------------------------------------------------------
	wire in_peri   = in_range(bus_addr_i, PERI_BASE, PERI_LIMIT);
	wire in_peri8  = in_range(bus_addr_i, PERI8_BASE, PERI8_LIMIT);
	wire ext_bad   = single_chip_q & in_range(bus_addr_i, EXT_BASE, EXT_LIMIT);
	wire fetch_err = bus_fetch_i & (bus_addr_i[0] | in_peri | ext_bad);
	wire word_odd  = (bus_size_i == SIZE_WORD) & bus_addr_i[0];
	wire long_mis  = (bus_size_i == SIZE_LONG) & (bus_addr_i[1:0] != 2'b00);
	wire long_p8   = (bus_size_i == SIZE_LONG) & in_peri8;
	wire data_err  = ~bus_fetch_i & (word_odd | long_mis | long_p8 | ext_bad);
	// the faulting cycle is not aborted; only a flag is recorded
	wire aerr_hit  = bus_valid_i & ~in_reset & (fetch_err | data_err);
	wire set_cpu   = aerr_hit & ~bus_dma_i;
	wire set_dma   = aerr_hit & bus_dma_i;

	// ----------------------------------------------------------------
	// acceptance and ranking
	// ----------------------------------------------------------------
	wire in_run    = (state_q == ST_RUN);
	wire accept_ok = in_run & dec_valid_i & ~dec_in_slot_i & ~async_q;
	wire int_ok    = accept_ok & ~dec_int_block_i;
	wire ubrk_ok   = ubrk_req_i & (LVL_UBRK > mask_q);
	wire irq_ok    = int_req_i & (int_level_i > mask_q);
	wire take_cpu  = accept_ok & aerr_cpu_q;
	wire take_dma  = accept_ok & aerr_dma_q & ~aerr_cpu_q;
	wire take_aerr = take_cpu | take_dma;
	wire take_int  = int_ok & ~take_aerr & (nmi_req_i | ubrk_ok | irq_ok);
	wire take_any  = take_aerr | take_int;

	wire [7:0] irq_vec  = int_ext_i ? (VEC_IRQ_BASE + {5'h0, int_line_i}) :
		((int_vec_i < VEC_PERI_LO) ? VEC_PERI_LO : int_vec_i);
	wire [7:0] take_vec = take_cpu ? VEC_AERR_CPU :
		take_dma ? VEC_AERR_DMA :
		nmi_req_i ? VEC_NMI :
		ubrk_ok ? VEC_UBRK : irq_vec;
	wire [3:0] take_lvl = nmi_req_i ? MASK_NMI : (ubrk_ok ? LVL_UBRK : int_level_i);

	// async work waits for the running instruction; instruction faults cannot preempt it
	wire go_async = in_run & async_q & instr_done_i;
	wire blocked  = async_q | take_any;
	wire go_trap  = in_run & ~blocked & trap_exec_i;
	wire slot_bad = dec_valid_i & dec_in_slot_i & (dec_undef_i | dec_pc_write_i);
	wire go_slot  = in_run & ~blocked & ~trap_exec_i & slot_bad;
	wire go_gen   = in_run & ~blocked & ~trap_exec_i & dec_valid_i & ~dec_in_slot_i &
		dec_undef_i;
	wire launch   = go_async | go_trap | go_slot | go_gen;

	wire [7:0]  launch_vec = go_async ? async_vec_q : go_trap ? trap_vec_i :
		go_slot ? VEC_ILL_SLOT : VEC_ILL_GEN;
	// address errors and interrupts stack the next instruction
	wire [31:0] launch_pc  = (go_async | go_trap) ? next_pc_i :
		go_slot ? slot_target_i : dec_pc_i;
	wire [31:0] sp_base_d  = launch ? stack_pointer_gpr_i : sp_base_q;
	wire [31:0] sr_push    = {status_word_i[31:SR_MASK_LSB + 4], mask_q,
		status_word_i[SR_MASK_LSB - 1:0]};

	// ----------------------------------------------------------------
	// next state
	// ----------------------------------------------------------------
	always_comb begin
		state_d = state_q;
		case (state_q)
			ST_HOLD: begin
				if (pin_release && rst_armed) begin
					state_d = ST_RST_PC;
				end
			end
			ST_RST_PC: begin
				if (mem_ack_i) begin
					state_d = ST_RST_SP;
				end
			end
			ST_RST_SP: begin
				if (mem_ack_i) begin
					state_d = ST_RST_INI;
				end
			end
			ST_RST_INI: state_d = ST_RUN;
			ST_RUN: begin
				if (launch) begin
					state_d = ST_PUSH_SR;
				end
			end
			ST_PUSH_SR: begin
				if (mem_ack_i) begin
					state_d = ST_PUSH_PC;
				end
			end
			ST_PUSH_PC: begin
				if (mem_ack_i) begin
					state_d = ST_FETCH;
				end
			end
			ST_FETCH: begin
				if (mem_ack_i) begin
					state_d = ST_JUMP;
				end
			end
			ST_JUMP: state_d = ST_RUN;
			default: state_d = ST_HOLD;
		endcase
		// the release cycle still reads as reset, so it must not pull the state back to hold
		if (in_reset && !pin_release) begin
			state_d = ST_HOLD;
		end
	end

	// ----------------------------------------------------------------
	// memory request for the coming state
	// ----------------------------------------------------------------
	logic        mreq_d, mwe_d;
	logic [31:0] maddr_d, mdata_d;
	always_comb begin
		mreq_d  = 1'b1;
		mwe_d   = 1'b0;
		maddr_d = 32'h0;
		mdata_d = 32'h0;
		case (state_d)
			ST_RST_PC:  maddr_d = vec_addr(vbr_q, VEC_RST_PC, 1'b0);
			ST_RST_SP:  maddr_d = vec_addr(vbr_q, VEC_RST_SP, 1'b0);
			ST_PUSH_SR: begin
				mwe_d   = 1'b1;
				maddr_d = sp_base_d - STACK_WORD;
				mdata_d = sr_push;
			end
			ST_PUSH_PC: begin
				mwe_d   = 1'b1;
				maddr_d = sp_base_q - (STACK_WORD + STACK_WORD);
				mdata_d = save_pc_q;
			end
			ST_FETCH:   maddr_d = vec_addr(vbr_q, exc_vec_q, 1'b1);
			default:    mreq_d  = 1'b0;
		endcase
	end

	// ----------------------------------------------------------------
	// register port decode
	// ----------------------------------------------------------------
	wire wr_vbr  = reg_wr_i & (reg_addr_i == REG_VBR);
	wire wr_mask = reg_wr_i & (reg_addr_i == REG_MASK);
	wire wr_mode = reg_wr_i & (reg_addr_i == REG_MODE);
	logic [31:0] rd_d;
	always_comb begin
		rd_d = 32'h0;
		if (reg_rd_i && reg_addr_i == REG_VBR) begin
			rd_d = vbr_q;
		end else if (reg_rd_i && reg_addr_i == REG_MASK) begin
			rd_d = {28'h0, mask_q};
		end else if (reg_rd_i && reg_addr_i == REG_MODE) begin
			rd_d = {31'h0, single_chip_q};
		end else if (reg_rd_i && reg_addr_i == REG_STAT) begin
			rd_d = {12'h0, exc_vec_q, async_q, aerr_dma_q, aerr_cpu_q, in_reset, 4'h0, state_q};
		end
	end

	// ----------------------------------------------------------------
	// reset pin synchroniser and low-time counter
	// ----------------------------------------------------------------
	always_ff @(posedge ref_clk_i or negedge arst_n_i) begin
		if (!arst_n_i) begin
			pin_s1_q    <= 1'b0;
			pin_s2_q    <= 1'b0;
			pin_s3_q    <= 1'b0;
			pin_level_q <= 1'b0;
			low_cnt_q   <= RST_MIN_CYC;
		end else begin
			pin_s1_q    <= external_reset_pin_n_i;
			pin_s2_q    <= pin_s1_q;
			pin_s3_q    <= pin_s2_q;
			pin_level_q <= pin_level_d;
			if (pin_level_q) begin
				low_cnt_q <= 5'h0;
			end else if (!rst_armed) begin
				low_cnt_q <= low_cnt_q + 5'h1;
			end
		end
	end

	// ----------------------------------------------------------------
	// sequencer and core state
	// ----------------------------------------------------------------
	always_ff @(posedge ref_clk_i or negedge arst_n_i) begin
		if (!arst_n_i) begin
			state_q       <= ST_HOLD;
			vbr_q         <= VBR_RESET;
			mask_q        <= MASK_RESET;
			single_chip_q <= 1'b0;
			aerr_cpu_q    <= 1'b0;
			aerr_dma_q    <= 1'b0;
			async_q       <= 1'b0;
			async_int_q   <= 1'b0;
			async_vec_q   <= 8'h0;
			async_lvl_q   <= 4'h0;
			exc_vec_q     <= 8'h0;
			exc_int_q     <= 1'b0;
			exc_lvl_q     <= 4'h0;
			save_pc_q     <= 32'h0;
			sp_base_q     <= 32'h0;
			pc_tmp_q      <= 32'h0;
		end else if (in_reset) begin
			state_q       <= state_d;
			vbr_q         <= VBR_RESET;
			mask_q        <= MASK_RESET;
			single_chip_q <= 1'b0;
			aerr_cpu_q    <= 1'b0;
			aerr_dma_q    <= 1'b0;
			async_q       <= 1'b0;
		end else begin
			state_q    <= state_d;
			sp_base_q  <= sp_base_d;
			// a new fault in the cycle it is taken stays pending
			aerr_cpu_q <= set_cpu | (aerr_cpu_q & ~take_cpu);
			aerr_dma_q <= set_dma | (aerr_dma_q & ~take_dma);
			if (take_any) begin
				async_q     <= 1'b1;
				async_int_q <= take_int;
				async_vec_q <= take_vec;
				async_lvl_q <= take_lvl;
			end else if (go_async) begin
				async_q <= 1'b0;
			end
			if (launch) begin
				exc_vec_q <= launch_vec;
				exc_int_q <= go_async & async_int_q;
				exc_lvl_q <= async_lvl_q;
				save_pc_q <= launch_pc;
			end
			if (state_q == ST_RST_PC && mem_ack_i) begin
				pc_tmp_q <= mem_rdata_i;
			end
			if (state_q == ST_RST_INI) begin
				vbr_q  <= VBR_RESET;
				mask_q <= MASK_RESET;
			end else if (state_q == ST_JUMP && exc_int_q) begin
				mask_q <= exc_lvl_q;
			end else if (wr_mask) begin
				mask_q <= reg_wdata_i[3:0];
			end
			if (wr_vbr && state_q != ST_RST_INI) begin
				vbr_q <= reg_wdata_i;
			end
			if (wr_mode) begin
				single_chip_q <= reg_wdata_i[0];
			end
		end
	end

	// ----------------------------------------------------------------
	// registered outputs
	// ----------------------------------------------------------------
	wire rst_load = (state_q == ST_RST_INI);
	wire exc_jump = (state_q == ST_JUMP);
	always_ff @(posedge ref_clk_i or negedge arst_n_i) begin
		if (!arst_n_i) begin
			reg_rdata_o  <= 32'h0;
			mem_req_o    <= 1'b0;
			mem_we_o     <= 1'b0;
			mem_addr_o   <= 32'h0;
			mem_wdata_o  <= 32'h0;
			pc_load_o    <= 1'b0;
			pc_val_o     <= 32'h0;
			sp_load_o    <= 1'b0;
			sp_val_o     <= 32'h0;
			cpu_hold_o   <= 1'b1;
			periph_rst_o <= 1'b1;
			aerr_o       <= 1'b0;
			int_ack_o    <= 1'b0;
			exc_vec_o    <= 8'h0;
		end else begin
			reg_rdata_o  <= rd_d;
			mem_req_o    <= mreq_d;
			mem_we_o     <= mwe_d;
			mem_addr_o   <= maddr_d;
			mem_wdata_o  <= mdata_d;
			// one-cycle PC load is the whole jump, no delay slot follows
			pc_load_o    <= (rst_load | (exc_jump && !in_reset));
			pc_val_o     <= rst_load ? pc_tmp_q : mem_rdata_q_sel(exc_jump);
			sp_load_o    <= (rst_load | (exc_jump && !in_reset));
			sp_val_o     <= rst_load ? mem_sp_q : sp_base_q - (STACK_WORD + STACK_WORD);
			cpu_hold_o   <= (state_d != ST_RUN);
			periph_rst_o <= in_reset;
			aerr_o       <= aerr_hit;
			int_ack_o    <= exc_jump & exc_int_q & ~in_reset;
			exc_vec_o    <= exc_vec_q;
		end
	end

	// vector fetch and reset SP word captured on their acks
	always_ff @(posedge ref_clk_i or negedge arst_n_i) begin
		if (!arst_n_i) begin
			vec_tgt_q <= 32'h0;
			mem_sp_q  <= 32'h0;
		end else begin
			if (state_q == ST_FETCH && mem_ack_i) begin
				vec_tgt_q <= mem_rdata_i;
			end
			if (state_q == ST_RST_SP && mem_ack_i) begin
				mem_sp_q <= mem_rdata_i;
			end
		end
	end

	function automatic logic [31:0] mem_rdata_q_sel(input logic sel);
		mem_rdata_q_sel = sel ? vec_tgt_q : 32'h0;
	endfunction

	assign imask_o = mask_q;

	// ----------------------------------------------------------------
	// checks
	// ----------------------------------------------------------------
	chk_rst_start: assert property (@(posedge ref_clk_i) disable iff (!arst_n_i)
		(state_q == ST_HOLD && pin_release && rst_armed) |=> (state_q == ST_RST_PC && mem_req_o))
		else $error("reset release did not start the fetch");
	chk_rst_fetch: assert property (@(posedge ref_clk_i) disable iff (!arst_n_i)
		(state_q == ST_RST_PC && mem_ack_i && pin_level_q) |=>
		(state_q == ST_RST_SP && mem_addr_o == 32'h0000_0004 && $past(mem_addr_o) == 32'h0))
		else $error("reset fetch order or address wrong");
	chk_rst_init: assert property (@(posedge ref_clk_i) disable iff (!arst_n_i)
		(state_q == ST_RST_INI && pin_level_q) |=> (vbr_q == 32'h0 && mask_q == 4'hF &&
		pc_load_o && pc_val_o == $past(pc_tmp_q)))
		else $error("reset did not clear base and set mask");
	chk_async_wait: assert property (@(posedge ref_clk_i) disable iff (!arst_n_i)
		(in_run && async_q && !instr_done_i && !in_reset) |=> (state_q == ST_RUN))
		else $error("async exception started before completion");
	chk_slot_hold: assert property (@(posedge ref_clk_i) disable iff (!arst_n_i)
		(in_run && !async_q && dec_valid_i && dec_in_slot_i) |=> !async_q)
		else $error("async exception taken in delay slot");
	chk_push_order: assert property (@(posedge ref_clk_i) disable iff (!arst_n_i)
		(state_q == ST_PUSH_SR && mem_ack_i && pin_level_q) |=>
		(state_q == ST_PUSH_PC && mem_we_o && mem_addr_o == $past(mem_addr_o) - 32'h4))
		else $error("stack push order wrong");
	chk_vec_fetch: assert property (@(posedge ref_clk_i) disable iff (!arst_n_i)
		(state_q == ST_FETCH && mem_req_o) |-> (mem_addr_o == vbr_q + {22'h0, exc_vec_q, 2'b00}))
		else $error("vector address wrong");
	chk_mask_keep: assert property (@(posedge ref_clk_i) disable iff (!arst_n_i)
		(state_q == ST_JUMP && !exc_int_q && !wr_mask && pin_level_q) |=> $stable(mask_q))
		else $error("mask changed by non-interrupt exception");
	chk_nmi_mask: assert property (@(posedge ref_clk_i) disable iff (!arst_n_i)
		(take_int && nmi_req_i) ##1 (!in_reset && !wr_mask) [*1] |->
		(async_lvl_q == 4'hF && async_vec_q == 8'h0B))
		else $error("NMI not taken at mask fifteen");
	chk_fetch_odd: assert property (@(posedge ref_clk_i) disable iff (!arst_n_i)
		(bus_valid_i && bus_fetch_i && bus_addr_i[0] && pin_level_q) |=> aerr_o)
		else $error("odd fetch not flagged");
	chk_long_align: assert property (@(posedge ref_clk_i) disable iff (!arst_n_i)
		(bus_valid_i && !bus_fetch_i && bus_size_i == 2'h2 && bus_addr_i[1:0] != 2'b00 &&
		pin_level_q) |=> aerr_o)
		else $error("misaligned longword not flagged");

endmodule

//--- test/vec_mem_model.sv
// Purpose: vector table and stack memory at the sequencer's far side
// Assumes: one word per request, ack lasts one cycle
// Notes:   read data follow the address so the bench can predict them
`timescale 1ns/1ps

module vec_mem_model #(
	parameter int WAIT_CYC = 2
) (
	input  wire logic        ref_clk_i,
	input  wire logic        mem_req_i,
	input  wire logic [31:0] mem_addr_i,
	output logic             mem_ack_o,
	output logic      [31:0] mem_rdata_o
);
	int wait_q = 0;

	initial begin
		mem_ack_o = 1'b0;
		mem_rdata_o = 32'h0;
	end

	// data toggle outside the ack cycle, so stale words are never mistaken for answers
	always @(posedge ref_clk_i) begin
		if (mem_ack_o || !mem_req_i) begin
			mem_ack_o <= 1'b0;
			wait_q <= 0;
			mem_rdata_o <= ~mem_rdata_o;
		end else if (wait_q < WAIT_CYC) begin
			wait_q <= wait_q + 1;
			mem_rdata_o <= ~mem_rdata_o;
		end else begin
			mem_ack_o <= 1'b1;
			mem_rdata_o <= mem_addr_i ^ 32'h5A5A_0000;
		end
	end
endmodule

//--- test/testbench.sv
// Purpose: self-checking bench for the exception sequencer
// Assumes: memory model waits two cycles before each ack
// Notes:   vector base 0x400 for the exception tests, stack 0x8000 and next pc 0x2000 throughout
`timescale 1ns/1ps

module testbench;
	import exc_seq_pkg::*;
	logic ref_clk_i, arst_n_i, external_reset_pin_n_i, reg_wr_i, reg_rd_i, dec_valid_i;
	logic dec_in_slot_i, dec_undef_i, dec_pc_write_i, dec_int_block_i, instr_done_i;
	logic trap_exec_i, nmi_req_i, ubrk_req_i, int_req_i, int_ext_i, bus_valid_i, bus_dma_i;
	logic bus_fetch_i, mem_ack_i, mem_req_o, mem_we_o, pc_load_o, sp_load_o, cpu_hold_o;
	logic periph_rst_o, aerr_o, int_ack_o;
	logic [1:0]  bus_size_i;
	logic [2:0]  int_line_i;
	logic [3:0]  int_level_i, imask_o;
	logic [7:0]  reg_addr_i, trap_vec_i, int_vec_i, exc_vec_o;
	logic [31:0] reg_wdata_i, reg_rdata_o, dec_pc_i, next_pc_i, slot_target_i, bus_addr_i;
	logic [31:0] status_word_i, stack_pointer_gpr_i, mem_addr_o, mem_wdata_o, mem_rdata_i;
	logic [31:0] pc_val_o, sp_val_o;
	logic [64:0] log_q[$];
	int          fail_count = 0;
	int          n_compared = 0;
	int          cyc = 0;

	exception_sequencer exception_sequencer_i (.*);
	vec_mem_model #(.WAIT_CYC(2)) vec_mem_model_i (.ref_clk_i(ref_clk_i), .mem_req_i(mem_req_o),
		.mem_addr_i(mem_addr_o), .mem_ack_o(mem_ack_i), .mem_rdata_o(mem_rdata_i));

	initial begin
		ref_clk_i = 1'b0;
		forever #25 ref_clk_i = ~ref_clk_i;
	end

	always @(posedge ref_clk_i) begin
		if (mem_req_o && mem_ack_i) begin
			log_q.push_back({mem_we_o, mem_addr_o, mem_wdata_o});
		end
		cyc++;
		if (cyc == 4000) begin
			fail_count++;
			complete_run();
		end
	end

	task automatic check(input logic [64:0] seen, input logic [64:0] exp);
		n_compared++;
		if (seen !== exp) begin
			fail_count++;
			$display("CHECK FAILED t=%0t seen=%h exp=%h", $time, seen, exp);
		end
	endtask

	task automatic complete_run();
		if (fail_count == 0 && n_compared > 0) begin
			$display("DONE - PASS");
		end else begin
			$display("DONE - FAIL");
		end
		$finish;
	endtask

	task automatic wait_load();
		for (int i = 0; i < 60 && pc_load_o !== 1'b1; i++) begin
			@(posedge ref_clk_i);
			#1;
		end
	endtask

	task automatic reg_write(input logic [7:0] a, input logic [31:0] d);
		@(posedge ref_clk_i);
		{reg_wr_i, reg_addr_i, reg_wdata_i} <= {1'b1, a, d};
		@(posedge ref_clk_i);
		reg_wr_i <= 1'b0;
	endtask

	task automatic reg_read(input logic [7:0] a, input logic [31:0] e);
		@(posedge ref_clk_i);
		{reg_rd_i, reg_addr_i} <= {1'b1, a};
		@(posedge ref_clk_i);
		reg_rd_i <= 1'b0;
		#1;
		check(reg_rdata_o, e);
	endtask

	task automatic bus(input logic f, input logic [1:0] s, input logic [31:0] a, input logic e);
		@(posedge ref_clk_i);
		{bus_valid_i, bus_fetch_i, bus_size_i, bus_addr_i} <= {1'b1, f, s, a};
		@(posedge ref_clk_i);
		bus_valid_i <= 1'b0;
		#1;
		check(aerr_o, e);
	endtask

	// one launch: stack the status word and pc, fetch the entry, load pc and sp
	task automatic exc(input logic trap, input logic slot, input logic undef,
		input logic [7:0] v, input logic [3:0] m0, input logic [3:0] m1, input logic [31:0] pc);
		logic [31:0] ea;
		ea = 32'h400 + {22'h0, v, 2'h0};
		log_q.delete();
		@(posedge ref_clk_i);
		{dec_valid_i, dec_in_slot_i, dec_undef_i, dec_pc_write_i, trap_exec_i} <=
			{!trap, slot, undef & !slot, undef & slot, trap};
		@(posedge ref_clk_i);
		{dec_valid_i, dec_in_slot_i, dec_undef_i, dec_pc_write_i, trap_exec_i} <= 5'h0;
		// a source taken at decode starts only on a later completion
		instr_done_i <= 1'b1;
		@(posedge ref_clk_i);
		instr_done_i <= 1'b0;
		wait_load();
		check(log_q[0], {1'b1, 32'h0000_7FFC, 24'h000003, m0, 4'h1});
		check(log_q[1], {1'b1, 32'h0000_7FF8, pc});
		check(log_q[2][64:32], {1'b0, ea});
		check(pc_val_o, ea ^ 32'h5A5A_0000);
		check(sp_val_o, 32'h0000_7FF8);
		check({sp_load_o, int_ack_o, cpu_hold_o}, {1'b1, m1 != m0, 1'b0});
		check(exc_vec_o, v);
		check(imask_o, m1);
	endtask

	initial begin
		{arst_n_i, external_reset_pin_n_i, reg_wr_i, reg_rd_i, dec_valid_i, dec_in_slot_i,
			dec_undef_i, dec_pc_write_i, dec_int_block_i, instr_done_i, trap_exec_i, nmi_req_i,
			ubrk_req_i, int_req_i, int_ext_i, bus_valid_i, bus_dma_i, bus_fetch_i, bus_size_i,
			int_line_i, int_level_i, reg_addr_i, int_vec_i, reg_wdata_i, dec_pc_i, slot_target_i,
			bus_addr_i} = '0;
		{next_pc_i, stack_pointer_gpr_i, status_word_i} = {32'h2000, 32'h8000, 32'h301};
		{dec_pc_i, slot_target_i} = {32'h2FFE, 32'h3000};
		trap_vec_i = 8'h20;
		repeat (4) @(posedge ref_clk_i);
		arst_n_i <= 1'b1;
		repeat (25) @(posedge ref_clk_i);
		#1;
		check(log_q.size(), 0);
		check(periph_rst_o, 1'b1);
		@(posedge ref_clk_i);
		external_reset_pin_n_i <= 1'b1;
		wait_load();
		check(log_q[0][64:32], 33'h0);
		check(log_q[1][64:32], 33'h4);
		check({pc_val_o, sp_val_o}, 64'h5A5A_0000_5A5A_0004);
		check(imask_o, 4'hF);
		reg_write(REG_VBR, 32'h400);
		reg_write(REG_MASK, 32'h3);
		reg_read(REG_VBR, 32'h400);
		reg_read(8'hFC, 32'h0);
		reg_read(REG_MASK, 32'h3);
		@(posedge ref_clk_i);
		{bus_valid_i, bus_size_i, bus_addr_i, nmi_req_i} <= {1'b1, SIZE_WORD, 32'h1001, 1'b1};
		@(posedge ref_clk_i);
		bus_valid_i <= 1'b0;
		#1;
		check(aerr_o, 1'b1);
		exc(1'b0, 1'b0, 1'b0, VEC_AERR_CPU, 4'h3, 4'h3, 32'h2000);
		exc(1'b0, 1'b0, 1'b0, VEC_NMI, 4'h3, 4'hF, 32'h2000);
		@(posedge ref_clk_i);
		nmi_req_i <= 1'b0;
		reg_write(REG_MASK, 32'h3);
		@(posedge ref_clk_i);
		{int_req_i, int_ext_i, int_line_i, int_level_i} <= {1'b1, 1'b1, 3'h2, 4'h5};
		exc(1'b0, 1'b0, 1'b0, 8'h42, 4'h3, 4'h5, 32'h2000);
		@(posedge ref_clk_i);
		int_req_i <= 1'b0;
		exc(1'b1, 1'b0, 1'b0, 8'h20, 4'h5, 4'h5, 32'h2000);
		@(posedge ref_clk_i);
		{int_req_i, int_ext_i, int_vec_i, int_level_i} <= {1'b1, 1'b0, 8'h30, 4'h7};
		exc(1'b0, 1'b1, 1'b1, VEC_ILL_SLOT, 4'h5, 4'h5, 32'h3000);
		exc(1'b0, 1'b0, 1'b0, VEC_PERI_LO, 4'h5, 4'h7, 32'h2000);
		@(posedge ref_clk_i);
		int_req_i <= 1'b0;
		exc(1'b0, 1'b0, 1'b1, VEC_ILL_GEN, 4'h7, 4'h7, 32'h2FFE);
		reg_write(REG_MODE, 32'h1);
		bus(1'b1, SIZE_WORD, 32'h0000_1001, 1'b1);
		bus(1'b0, SIZE_LONG, 32'h0000_1002, 1'b1);
		bus(1'b0, SIZE_LONG, 32'hF000_0004, 1'b1);
		bus(1'b0, SIZE_LONG, 32'hF010_0000, 1'b0);
		bus(1'b0, SIZE_BYTE, 32'h1000_0000, 1'b1);
		bus(1'b1, SIZE_WORD, 32'hF010_0000, 1'b1);
		reg_read(REG_STAT, 32'h0000_4206);
		@(posedge ref_clk_i);
		external_reset_pin_n_i <= 1'b0;
		repeat (25) @(posedge ref_clk_i);
		#1;
		check(periph_rst_o, 1'b1);
		@(posedge ref_clk_i);
		external_reset_pin_n_i <= 1'b1;
		wait_load();
		check({pc_val_o, sp_val_o}, 64'h5A5A_0000_5A5A_0004);
		check(imask_o, 4'hF);
		reg_read(REG_MODE, 32'h0);
		reg_read(REG_VBR, 32'h0);
		complete_run();
	end
endmodule
